/* src/aic_alarm_input_conditioner.sv */
// Alarm and message input conditioner with APB register access.
//
// Contract
// RULE1 - Inputs disabled after reset until configured.
// RULE2 - Quiescent-current input alarms when voltage absent.
// RULE3 - Operating-current input alarms when voltage present.
// RULE4 - Per-input delay 0..255 minutes before signalling.
// RULE5 - Per-input 19-character text reported with events.
// RULE6 - Per-input priority 0..99 classifies events.
// RULE7 - Multiples of ten only logged as messages.
// RULE8 - Other priorities become forwarded alarms.
// RULE9 - Module failure: one alarm, then inputs unmonitored.
// RULE10 - Two local plus four twelve-input modules.
// RULE11 - Condition clearing early restarts delay, no alarm.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module aic_alarm_input_conditioner
#(
    parameter logic [31:0] MinuteCycles = aic_pkg::MINUTE_CYCLES
)
(
    input  wire logic                     clock,
    input  wire logic                     resetn,
    input  wire aic_pkg::aic_apb_req_t    apbReq,
    output var  aic_pkg::aic_apb_rsp_t    apbRsp,
    input  wire logic [1:0]               localInputs,
    input  wire logic [47:0]              extInputs,
    input  wire logic [3:0]               moduleOnline,
    output var  aic_pkg::aic_event_t      eventData,
    output logic                          eventValid,
    output logic                          irq
);
    import aic_pkg::*;

    // All state of the conditioner lives in one packed struct.
    // The synchroniser stages come first, because every contact and every
    // module presence line is asynchronous to the clock and must pass two
    // flip-flops before any decision logic may look at it.
    // The configuration and text arrays are written only over the bus; the
    // per-input counters, fired flags and pending flags are hardware state.
    // Keeping everything in one struct makes the reset a single assignment,
    // at the cost of a rather wide register that synthesis splits anyway.
    typedef struct packed {
        logic [NUM_IN-1:0]               sync1;
        logic [NUM_IN-1:0]               sync2;
        logic [NUM_MOD-1:0]              onl1;
        logic [NUM_MOD-1:0]              onl2;
        logic [31:0]                     presc;
        logic                            tick;
        aic_cfg_t [NUM_IN-1:0]           cfg;
        logic [NUM_IN-1:0][TEXT_W-1:0]   text;
        logic [NUM_IN-1:0][DLY_W-1:0]    cnt;
        logic [NUM_IN-1:0]               fired;
        logic [NUM_MOD-1:0]              modEn;
        logic [NUM_MOD-1:0]              modFailed;
        logic [NUM_EVT-1:0]              pend;
        logic [ST_W-1:0]                 status;
        logic [ST_W-1:0]                 mask;
        aic_event_t                      evt;
        logic                            evtValid;
        logic                            irq;
        aic_apb_rsp_t                    apb;
    } aic_state_t;

    aic_state_t s_q;
    aic_state_t s_d;

    // Address decoding, shared by the read and the write path.
    function automatic aic_dec_t decode(input logic [11:0] addr);
        aic_dec_t    d;
        logic [11:0] off;
        d      = '{kind: REG_NONE, idx: '0, word: '0};
        off    = '0;
        if (addr[1:0] == 2'h0)
        begin
            if (addr == OFF_CTRL) d.kind = REG_CTRL;
            else if (addr == OFF_STATUS) d.kind = REG_STATUS;
            else if (addr == OFF_MASK) d.kind = REG_MASK;
            else if (addr == OFF_EVENT) d.kind = REG_EVENT;
            else if (addr == OFF_MODSTAT) d.kind = REG_MODSTAT;
            else if (addr >= OFF_CFG_BASE && addr < OFF_TEXT_BASE)
            begin
                off = addr - OFF_CFG_BASE;
                if (off[11:2] < 10'(NUM_IN))
                begin
                    d.kind = REG_CFG;
                    d.idx  = off[7:2];
                end
            end
            else if (addr >= OFF_TEXT_BASE)
            begin
                off = addr - OFF_TEXT_BASE;
                if (off[11:5] < 7'(NUM_IN) && off[4:2] < 3'(TEXT_WORDS))
                begin
                    d.kind = REG_TEXT;
                    d.idx  = off[10:5];
                    d.word = off[4:2];
                end
            end
        end
        return d;
    endfunction : decode

    // Priorities that are multiples of ten are message-only.
    function automatic logic isAlarmPrio(input logic [PRIO_W-1:0] p);
        return (p % PRIO_STEP) != 7'h00;
    endfunction : isAlarmPrio

    aic_dec_t         dec;
    logic             access;
    logic             doWrite;
    logic [31:0]      rdata;
    logic [NUM_EVT-1:0] pendSet;
    logic [ST_W-1:0]  stSet;
    logic [ST_W-1:0]  stClr;
    logic [NUM_MOD-1:0] failNow;
    logic             act;
    logic             blocked;
    logic [IDX_W-1:0] pick;
    logic             found;
    int               bytePos;
    logic [NUM_IN-1:0] blockVec;

    // Notes for users of the block.
    // Delays are counted in ticks of a free-running minute prescaler, so a
    // programmed delay of N minutes really lasts between N-1 and N minutes.
    // A shared prescaler was chosen over one counter per input; a per-input
    // counter of the full minute width would cost far more area.
    // An input raises one event per active episode; it re-arms only after
    // its condition has cleared or its module has failed, which keeps a stuck contact from flooding
    // the event queue.
    // Pending events leave one per cycle, lowest index first, so the local
    // contacts always win over the extension lines and module failures.

    always_comb
    begin
        s_d      = s_q;
        dec      = decode(apbReq.paddr);
        access   = apbReq.psel & apbReq.penable;
        doWrite  = access & apbReq.pwrite & s_q.apb.pready;
        rdata    = '0;
        pendSet  = '0;
        stSet    = '0;
        stClr    = '0;
        failNow  = '0;
        act      = 1'b0;
        blocked  = 1'b0;
        pick     = '0;
        found    = 1'b0;
        bytePos  = 0;
        blockVec = '0;

        // Two-stage synchronisers; the first stage feeds only the second.
        // RULE10 two local inputs, then 4 x 12 extension inputs.
        s_d.sync1 = {extInputs, localInputs};
        s_d.sync2 = s_q.sync1;
        s_d.onl1  = moduleOnline;
        s_d.onl2  = s_q.onl1;

        // Free-running minute prescaler; delays advance on its tick.
        if (s_q.presc >= MinuteCycles - 32'h1)
        begin
            s_d.presc = '0;
            s_d.tick  = 1'b1;
        end
        else
        begin
            s_d.presc = s_q.presc + 32'h1;
            s_d.tick  = 1'b0;
        end

        // Read data, registered on the same edge on which pready rises.
        unique case (dec.kind)
            REG_CTRL:    rdata = {28'h0, s_q.modEn};
            REG_STATUS:  rdata = {29'h0, s_q.status};
            REG_MASK:    rdata = {29'h0, s_q.mask};
            REG_EVENT:   rdata = {9'h0, s_q.evt.prio, 7'h0, s_q.evt.isAlarm, 2'h0, s_q.evt.index};
            REG_MODSTAT: rdata = {20'h0, s_q.modEn, s_q.onl2, s_q.modFailed};
            REG_CFG:     rdata = {9'h0, s_q.cfg[dec.idx].prio, s_q.cfg[dec.idx].delay,
                                  6'h0, s_q.cfg[dec.idx].quiescent, s_q.cfg[dec.idx].enable};
            REG_TEXT:
            begin
                for (int b = 0; b < 4; b++)
                begin
                    bytePos = 4 * int'(dec.word) + b;
                    if (bytePos < TEXT_LEN)
                        rdata[8*b +: 8] = s_q.text[dec.idx][8*bytePos +: 8];
                end
            end
            REG_NONE:    rdata = '0;
        endcase

        // One wait state: pready rises in the second access cycle.
        if (access && !s_q.apb.pready)
        begin
            s_d.apb.pready  = 1'b1;
            s_d.apb.prdata  = rdata;
            s_d.apb.pslverr = (dec.kind == REG_NONE);
        end
        else
        begin
            s_d.apb.pready  = 1'b0;
            s_d.apb.pslverr = 1'b0;
        end

        // Register writes take effect on the edge that completes the access.
        if (doWrite)
        begin
            unique case (dec.kind)
                REG_CTRL:   s_d.modEn = apbReq.pwdata[3:0];
                REG_STATUS: stClr     = apbReq.pwdata[ST_W-1:0];
                REG_MASK:   s_d.mask  = apbReq.pwdata[ST_W-1:0];
                REG_CFG:
                begin
                    s_d.cfg[dec.idx].enable    = apbReq.pwdata[CFG_EN_POS];
                    // RULE2 quiescent selects low-active.
                    s_d.cfg[dec.idx].quiescent = apbReq.pwdata[CFG_QC_POS];
                    // RULE4 delay in whole minutes.
                    s_d.cfg[dec.idx].delay     = apbReq.pwdata[CFG_DLY_POS +: DLY_W];
                    // RULE6 priority saturates at its top value.
                    if (apbReq.pwdata[CFG_PRIO_POS +: PRIO_W] > PRIO_MAX)
                        s_d.cfg[dec.idx].prio = PRIO_MAX;
                    else
                        s_d.cfg[dec.idx].prio = apbReq.pwdata[CFG_PRIO_POS +: PRIO_W];
                end
                REG_TEXT:
                begin
                    // RULE5 only nineteen characters are stored.
                    for (int b = 0; b < 4; b++)
                    begin
                        bytePos = 4 * int'(dec.word) + b;
                        if (bytePos < TEXT_LEN)
                            s_d.text[dec.idx][8*bytePos +: 8] = apbReq.pwdata[8*b +: 8];
                    end
                end
                default:    s_d.modEn = s_q.modEn;
            endcase
        end

        // RULE9 a newly failed module raises exactly one alarm.
        failNow       = s_q.modEn & ~s_q.onl2;
        s_d.modFailed = failNow;
        for (int m = 0; m < NUM_MOD; m++)
            pendSet[NUM_IN + m] = failNow[m] & ~s_q.modFailed[m];

        // Spread each module's failure flag over its twelve lines.
        // Building the mask per module keeps every array index in range,
        // so the local contacts never address a module that is not there.
        // A failed module's lines float, so their synced values are junk;
        // the mask is taken from the registered flag, which is set in the
        // same cycle in which junk first reaches the second sync stage.
        for (int m = 0; m < NUM_MOD; m++)
        begin
            blockVec[NUM_LOCAL + IN_PER_MOD * m +: IN_PER_MOD] = {IN_PER_MOD{s_q.modFailed[m]}};
        end

        // Per-input condition and delay.
        for (int i = 0; i < NUM_IN; i++)
        begin
            // RULE9 inputs of a failed module are not monitored.
            blocked = blockVec[i];
            // RULE1 RULE2 RULE3 enable gate and polarity.
            act = s_q.cfg[i].enable & (s_q.sync2[i] ^ s_q.cfg[i].quiescent);
            if (!act || blocked)
            begin
                // RULE11 restart the delay, no event.
                s_d.cnt[i]   = '0;
                s_d.fired[i] = 1'b0;
            end
            else if (!s_q.fired[i])
            begin
                // RULE4 signal once the delay has run.
                if (s_q.cnt[i] >= s_q.cfg[i].delay)
                begin
                    s_d.fired[i] = 1'b1;
                    pendSet[i]   = 1'b1;
                end
                else if (s_q.tick)
                    s_d.cnt[i] = s_q.cnt[i] + 8'h01;
            end
        end

        // Lowest pending event is issued first, one per cycle.
        for (int k = NUM_EVT - 1; k >= 0; k--)
        begin
            if (s_q.pend[k])
            begin
                pick  = IDX_W'(k);
                found = 1'b1;
            end
        end
        s_d.evtValid = found;
        if (found)
        begin
            s_d.pend[pick] = 1'b0;
            s_d.evt.index  = pick;
            if (pick >= IDX_W'(NUM_IN))
            begin
                s_d.evt.isAlarm = 1'b1;
                s_d.evt.prio    = MOD_FAIL_PRIO;
                s_d.evt.text    = '0;
                stSet[ST_MODF]  = 1'b1;
                stSet[ST_ALM]   = 1'b1;
            end
            else
            begin
                // RULE7 RULE8 classify by priority.
                s_d.evt.isAlarm = isAlarmPrio(s_q.cfg[pick].prio);
                s_d.evt.prio    = s_q.cfg[pick].prio;
                // RULE5 text travels with the event.
                s_d.evt.text    = s_q.text[pick];
                stSet[ST_ALM]   = isAlarmPrio(s_q.cfg[pick].prio);
                stSet[ST_MSG]   = ~isAlarmPrio(s_q.cfg[pick].prio);
            end
        end
        // A set arriving with the pick still wins.
        s_d.pend = s_d.pend | pendSet;

        // Sticky status: a new event beats a write-one clear.
        s_d.status = (s_q.status & ~stClr) | stSet;
        s_d.irq    = |(s_d.status & s_d.mask);
    end

    // Synchronous reset leaves every input disabled and all flags clear.
    // Reset must be held for at least one edge; the bus may start its
    // first setup cycle at the first edge after release.
    always_ff @(posedge clock)
    begin
        if (!resetn)
            s_q <= {$bits(aic_state_t){RESET_VAL}};
        else
            s_q <= s_d;
    end

    assign apbRsp     = s_q.apb;
    assign eventData  = s_q.evt;
    assign eventValid = s_q.evtValid;
    assign irq        = s_q.irq;
endmodule : aic_alarm_input_conditioner
`default_nettype wire

/* src/aic_pkg.sv */
// Package with constants and types of the alarm input conditioner.
package aic_pkg;
    localparam int NUM_LOCAL  = 2;
    localparam int NUM_MOD    = 4;
    localparam int IN_PER_MOD = 12;
    localparam int NUM_IN     = NUM_LOCAL + NUM_MOD * IN_PER_MOD;
    localparam int NUM_EVT    = NUM_IN + NUM_MOD;
    localparam int IDX_W      = 6;
    localparam int PRIO_W     = 7;
    localparam int DLY_W      = 8;
    localparam int TEXT_LEN   = 19;
    localparam int TEXT_W     = TEXT_LEN * 8;
    localparam int TEXT_WORDS = 5;
    // Clock rate and one minute expressed in cycles.
    localparam longint CLK_HZ        = 50_000_000;
    localparam longint MINUTE_S      = 60;
    localparam logic [31:0] MINUTE_CYCLES = 32'(CLK_HZ * MINUTE_S);
    localparam logic [PRIO_W-1:0] PRIO_MAX      = 7'h63;
    localparam logic [PRIO_W-1:0] MOD_FAIL_PRIO = 7'h01;
    localparam logic [PRIO_W-1:0] PRIO_STEP     = 7'h0a;
    // Register byte offsets.
    localparam logic [11:0] OFF_CTRL      = 12'h000;
    localparam logic [11:0] OFF_STATUS    = 12'h004;
    localparam logic [11:0] OFF_MASK      = 12'h008;
    localparam logic [11:0] OFF_EVENT     = 12'h00c;
    localparam logic [11:0] OFF_MODSTAT   = 12'h010;
    localparam logic [11:0] OFF_CFG_BASE  = 12'h100;
    localparam logic [11:0] OFF_TEXT_BASE = 12'h400;
    // Status bit positions.
    localparam int ST_MSG  = 0;
    localparam int ST_ALM  = 1;
    localparam int ST_MODF = 2;
    localparam int ST_W    = 3;
    // Configuration field positions inside a configuration word, and the alarm bit of the event word.
    localparam int CFG_EN_POS   = 0;
    localparam int CFG_QC_POS   = 1;
    localparam int CFG_DLY_POS  = 8;
    localparam int CFG_PRIO_POS = 16;
    localparam int EVT_ALM_POS  = 8;
    // Value of all state after reset.
    localparam logic RESET_VAL = 1'b0;

    typedef enum logic [2:0] {
        REG_CTRL, REG_STATUS, REG_MASK, REG_EVENT,
        REG_MODSTAT, REG_CFG, REG_TEXT, REG_NONE
    } aic_reg_t;

    typedef struct packed {
        aic_reg_t               kind;
        logic [IDX_W-1:0]       idx;
        logic [2:0]             word;
    } aic_dec_t;

    typedef struct packed {
        logic [PRIO_W-1:0] prio;
        logic [DLY_W-1:0]  delay;
        logic              quiescent;
        logic              enable;
    } aic_cfg_t;

    typedef struct packed {
        logic [IDX_W-1:0]  index;
        logic              isAlarm;
        logic [PRIO_W-1:0] prio;
        logic [TEXT_W-1:0] text;
    } aic_event_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } aic_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } aic_apb_rsp_t;
endpackage : aic_pkg

/* verif/aic_checker_asserts.sv */
// Concurrent checks on the conditioner's ports.
`timescale 1ns/1ns
`default_nettype none
module aic_checker_asserts
(
    input wire logic                  clock,
    input wire logic                  resetn,
    input wire aic_pkg::aic_apb_req_t apbReq,
    input wire aic_pkg::aic_apb_rsp_t apbRsp,
    input wire logic [1:0]            localInputs,
    input wire logic [47:0]           extInputs,
    input wire logic [3:0]            moduleOnline,
    input wire aic_pkg::aic_event_t   eventData,
    input wire logic                  eventValid,
    input wire logic                  irq
);
    import aic_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    // The first access edge never answers; the next one always does.
    AST_RDY_LAT: assert property (apbReq.psel && apbReq.penable && $past(apbReq.psel && !apbReq.penable)
        |-> !apbRsp.pready ##1 apbRsp.pready) else $error("pready latency wrong");
    AST_RDY_PULSE: assert property (apbRsp.pready |=> !apbRsp.pready) else $error("pready longer than one cycle");
    AST_RDY_REQ: assert property (apbRsp.pready |-> $past(apbReq.psel && apbReq.penable))
        else $error("pready without access");
    AST_ERR: assert property (apbRsp.pslverr |-> apbRsp.pready) else $error("pslverr without pready");
    // Event data may only move together with the valid pulse.
    AST_EVT_HOLD: assert property ($past(resetn) && !eventValid |-> $stable(eventData)) else $error("event data moved");
    AST_QUIET: assert property ($rose(resetn) |-> !eventValid [*4]) else $error("event after reset");
    AST_PRIO_MAX: assert property (eventValid |-> eventData.prio <= PRIO_MAX) else $error("priority too big");
    AST_CLASS_MSG: assert property (eventValid && eventData.prio % 10 == 0 |-> !eventData.isAlarm)
        else $error("message sent as alarm");
    AST_CLASS_ALM: assert property (eventValid && eventData.prio % 10 != 0 |-> eventData.isAlarm)
        else $error("alarm sent as message");
    AST_INDEX: assert property (eventValid |-> eventData.index < 6'h36) else $error("index out of range");
    AST_MODF: assert property (eventValid && eventData.index >= 6'h32
        |-> eventData.isAlarm && eventData.prio == MOD_FAIL_PRIO) else $error("module failure event wrong");

    COV_ALM: cover property (eventValid && eventData.isAlarm);
    COV_MSG: cover property (eventValid && !eventData.isAlarm);
    COV_ERR: cover property (apbRsp.pslverr);
endmodule : aic_checker_asserts

bind aic_alarm_input_conditioner aic_checker_asserts aic_checker_asserts_inst (.clock, .resetn, .apbReq,
    .apbRsp, .localInputs, .extInputs, .moduleOnline, .eventData, .eventValid, .irq);
`default_nettype wire

/* verif/aic_field_model.sv */
// Field contacts and extension input modules seen from the conditioner.
`timescale 1ns/1ns
`default_nettype none
module aic_field_model
(
    input  wire logic        clock,
    input  wire logic [1:0]  localSet,
    input  wire logic [47:0] extSet,
    input  wire logic [3:0]  modAlive,
    output logic      [1:0]  localInputs,
    output logic      [47:0] extInputs,
    output logic      [3:0]  moduleOnline
);
    logic [3:0]  aliveQ = 4'hf;
    logic [47:0] junkQ = 48'h0;

    // A dead module's lines float, so they toggle every cycle from the cycle after it dies.
    always @(posedge clock)
    begin
        aliveQ <= modAlive;
        junkQ <= ~junkQ;
    end
    assign localInputs = localSet;
    assign moduleOnline = modAlive;
    for (genvar m = 0; m < 4; m++)
    begin : gMod
        assign extInputs[12*m +: 12] = aliveQ[m] ? extSet[12*m +: 12] : junkQ[12*m +: 12];
    end
endmodule : aic_field_model
`default_nettype wire

/* verif/alarm_input_conditioner_tb.sv */
// Register level bench of the alarm input conditioner.
`timescale 1ns/1ns
`default_nettype none
module alarm_input_conditioner_tb;
    import aic_pkg::*;
    localparam int Mc = 20;
    logic         clock, resetn, eventValid, irq, er;
    aic_apb_req_t apbReq;
    aic_apb_rsp_t apbRsp;
    logic [1:0]   localSet, localInputs;
    logic [47:0]  extSet, extInputs;
    logic [3:0]   modAlive, moduleOnline;
    aic_event_t   eventData, lastEvt;
    logic [31:0]  rd;
    logic [6:0]   pr [6] = '{7'h00, 7'h0a, 7'h5a, 7'h01, 7'h63, 7'h7f};
    int           err_count, num_checks, nEvt;

    aic_field_model aic_field_model_inst (.clock, .localSet, .extSet, .modAlive, .localInputs, .extInputs,
        .moduleOnline);
    aic_alarm_input_conditioner #(.MinuteCycles(32'(Mc))) aic_alarm_input_conditioner_inst (.clock, .resetn,
        .apbReq, .apbRsp, .localInputs, .extInputs, .moduleOnline, .eventData, .eventValid, .irq);

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // Keep the newest event and count them all.
    always @(posedge clock)
    begin
        if (eventValid === 1'b1)
        begin
            lastEvt <= eventData;
            nEvt <= nEvt + 1;
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
            err_count++;
        end
    endtask : chk
    // One APB transfer; the request is held until pready is sampled.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        apbReq <= '{1'b1, 1'b0, w, a, d};
        @(posedge clock);
        apbReq.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (apbRsp.pready !== 1'b1 && n < 40);
        rd = apbRsp.prdata;
        er = apbRsp.pslverr;
        apbReq <= '0;
        if (n >= 40) err_count++;
    endtask : apb
    task automatic waitEvt(input int lim, output int n);
        int c0;
        c0 = nEvt;
        n = 0;
        while (nEvt == c0 && n < lim)
        begin
            @(posedge clock);
            n++;
        end
        if (n >= lim) err_count++;
    endtask : waitEvt
    task automatic pin(input int i, input logic v);
        @(posedge clock);
        if (i < 2) localSet[i] <= v;
        else extSet[i-2] <= v;
    endtask : pin
    task automatic stop_test();
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test

    // The whole sequence needs a few hundred cycles.
    initial
    begin
        #400_000;
        err_count++;
        stop_test();
    end

    initial
    begin
        int n, c;
        logic [6:0] s;
        resetn = 1'b0;
        apbReq = '0;
        localSet = '0;
        extSet = '0;
        modAlive = 4'hf;
        nEvt = 0;
        err_count = 0;
        num_checks = 0;
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        localSet <= 2'h3;
        extSet <= '1;
        repeat (20) @(posedge clock);
        chk(nEvt, 0);
        localSet <= 2'h0;
        extSet <= '0;
        apb(1'b0, OFF_CFG_BASE, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, OFF_MASK, 32'h2);
        // Every priority class on a high-active local contact.
        foreach (pr[k])
        begin
            s = (pr[k] > 7'h63) ? 7'h63 : pr[k];
            apb(1'b1, OFF_CFG_BASE, {9'h0, pr[k], 16'h0001});
            pin(0, 1'b1);
            waitEvt(20, n);
            chk(lastEvt.index, 32'h0);
            chk(lastEvt.prio, s);
            chk(lastEvt.isAlarm, s % 10 != 0);
            pin(0, 1'b0);
            repeat (6) @(posedge clock);
        end
        chk(irq, 1'b1);
        apb(1'b1, OFF_STATUS, 32'h3);
        repeat (2) @(posedge clock);
        chk(irq, 1'b0);
        // Low-active contact with its own text fires at once.
        apb(1'b1, OFF_TEXT_BASE + 12'h020, 32'h44434241);
        apb(1'b1, OFF_CFG_BASE + 12'h004, 32'h00140003);
        waitEvt(20, n);
        chk(lastEvt.index, 32'h1);
        chk(lastEvt.text[31:0], 32'h44434241);
        pin(1, 1'b1);
        // Two minute delay on the first extension line.
        apb(1'b1, OFF_CFG_BASE + 12'h008, 32'h00030201);
        c = nEvt;
        pin(2, 1'b1);
        repeat (15) @(posedge clock);
        pin(2, 1'b0);
        repeat (50) @(posedge clock);
        chk(nEvt, c);
        pin(2, 1'b1);
        waitEvt(80, n);
        chk(n > 20 && n <= 46, 1'b1);
        chk(lastEvt.index, 32'h2);
        // Module failure blocks its lines.
        apb(1'b1, OFF_CTRL, 32'h1);
        pin(2, 1'b0);
        repeat (10) @(posedge clock);
        modAlive <= 4'he;
        waitEvt(20, n);
        chk(lastEvt.index, 32'h32);
        c = nEvt;
        pin(2, 1'b1);
        repeat (60) @(posedge clock);
        chk(nEvt, c);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd[2], 1'b1);
        apb(1'b0, OFF_EVENT, 32'h0);
        chk(rd, 32'h00010132);
        apb(1'b0, OFF_MODSTAT, 32'h0);
        chk(rd, 32'h000001e1);
        apb(1'b0, 12'h020, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        stop_test();
    end
endmodule : alarm_input_conditioner_tb
`default_nettype wire
